// File: hw/osmc_pkg.sv
package osmc_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB side)
  // ==========================================================
  localparam logic [7:0] OSMC_CFG_OFS = 8'h00;
  localparam logic [7:0] OSMC_ALLOC_OFS = 8'h04;
  localparam logic [7:0] OSMC_TORQUE_OFS = 8'h08;
  localparam logic [7:0] OSMC_CTRL_OFS = 8'h0C;
  localparam logic [7:0] OSMC_STATUS_OFS = 8'h10;

  // ==========================================================
  // Field layout
  // ==========================================================
  localparam int OSMC_CFG_FWD_DIS_BIT = 0;
  localparam int OSMC_CFG_REV_DIS_BIT = 1;
  localparam int OSMC_CFG_G1_LSB = 4;
  localparam int OSMC_CFG_OT_LSB = 8;
  localparam int OSMC_CFG_G2_LSB = 12;
  localparam int OSMC_CTRL_RESTART_BIT = 0;
  localparam int OSMC_CTRL_CLEAR_BIT = 1;

  // ==========================================================
  // Reset values and limits
  // ==========================================================
  localparam logic [31:0] OSMC_CFG_RST = 32'h0000_0000;
  localparam logic [3:0] OSMC_ALLOC_RST = 4'h1;
  localparam logic [3:0] OSMC_ALLOC_MAP_A = 4'h1;
  localparam logic [3:0] OSMC_ALLOC_MAP_B = 4'h2;
  localparam logic [8:0] OSMC_TORQUE_RST = 9'h12C;
  localparam logic [8:0] OSMC_TORQUE_MAX = 9'h15E;
  localparam logic [2:0] OSMC_G2_SEL_WARN = 3'h5;
  localparam logic [31:0] OSMC_RDATA_ZERO = 32'h0000_0000;

  // ==========================================================
  // Enumerations
  // ==========================================================
  typedef enum logic [1:0] {
    OSMC_METH_NONE,
    OSMC_METH_DB,
    OSMC_METH_COAST,
    OSMC_METH_REVB
  } osmc_meth_type;

  typedef enum logic [1:0] {
    OSMC_POST_OPER,
    OSMC_POST_COAST,
    OSMC_POST_DB,
    OSMC_POST_ZCLAMP
  } osmc_post_type;

  typedef enum logic [2:0] {
    OSMC_CAUSE_NONE,
    OSMC_CAUSE_G1,
    OSMC_CAUSE_G2,
    OSMC_CAUSE_OT,
    OSMC_CAUSE_SOFF
  } osmc_cause_type;

endpackage

// File: hw/osmc_stop_select.sv
`timescale 1ns/1ps
`default_nettype none
module osmc_stop_select
  import osmc_pkg::*;
(
  input wire osmc_cause_type i_cause,
  input wire logic [1:0] i_group_one_stop_sel,
  input wire logic [1:0] i_overtravel_stop_sel,
  input wire logic [2:0] i_group_two_stop_sel,
  output osmc_meth_type o_method,
  output osmc_post_type o_post
);

  // ==========================================================
  // Decode of the latched selections per stop cause
  // ==========================================================
  always_comb begin
    o_method = OSMC_METH_NONE;
    o_post = OSMC_POST_OPER;
    case (i_cause)
      OSMC_CAUSE_G1, OSMC_CAUSE_SOFF: begin
        case (i_group_one_stop_sel)
          2'h1: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_DB;
          end
          2'h2: begin
            o_method = OSMC_METH_COAST;
            o_post = OSMC_POST_COAST;
          end
          // Undefined code 3 falls back to the safe default
          default: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_COAST;
          end
        endcase
      end
      OSMC_CAUSE_OT: begin
        case (i_overtravel_stop_sel)
          2'h1: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_DB;
          end
          2'h2: begin
            o_method = OSMC_METH_REVB;
            o_post = OSMC_POST_ZCLAMP;
          end
          2'h3: begin
            o_method = OSMC_METH_REVB;
            o_post = OSMC_POST_COAST;
          end
          default: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_COAST;
          end
        endcase
      end
      OSMC_CAUSE_G2: begin
        case (i_group_two_stop_sel)
          3'h1: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_DB;
          end
          3'h2: begin
            o_method = OSMC_METH_COAST;
            o_post = OSMC_POST_COAST;
          end
          3'h3: begin
            o_method = OSMC_METH_REVB;
            o_post = OSMC_POST_DB;
          end
          3'h4: begin
            o_method = OSMC_METH_REVB;
            o_post = OSMC_POST_COAST;
          end
          3'h5: begin
            o_method = OSMC_METH_NONE;
            o_post = OSMC_POST_OPER;
          end
          default: begin
            o_method = OSMC_METH_DB;
            o_post = OSMC_POST_COAST;
          end
        endcase
      end
      default: begin
        o_method = OSMC_METH_NONE;
        o_post = OSMC_POST_OPER;
      end
    endcase
  end

endmodule
`default_nettype wire

// File: hw/osmc_apb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module osmc_apb_regs
  import osmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] i_status,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_cfg,
  output logic [3:0] o_alloc,
  output logic [8:0] o_torque,
  output logic o_restart,
  output logic o_clear
);

  logic setup;
  logic wr_en;
  logic mapped;

  // ==========================================================
  // APB slave: no wait state, answer in the first access cycle
  // ==========================================================
  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
  assign mapped = (i_paddr == OSMC_CFG_OFS) || (i_paddr == OSMC_ALLOC_OFS) ||
                  (i_paddr == OSMC_TORQUE_OFS) || (i_paddr == OSMC_CTRL_OFS) ||
                  (i_paddr == OSMC_STATUS_OFS);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= OSMC_RDATA_ZERO;
    end else if (setup && !i_pwrite) begin
      case (i_paddr)
        OSMC_CFG_OFS: o_prdata <= o_cfg;
        OSMC_ALLOC_OFS: o_prdata <= {28'h0000000, o_alloc};
        OSMC_TORQUE_OFS: o_prdata <= {23'h000000, o_torque};
        OSMC_STATUS_OFS: o_prdata <= i_status;
        default: o_prdata <= OSMC_RDATA_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Writable registers
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg <= OSMC_CFG_RST;
      o_alloc <= OSMC_ALLOC_RST;
    end else if (wr_en) begin
      if (i_paddr == OSMC_CFG_OFS) begin
        o_cfg <= i_pwdata & 32'h0000_733F;
      end
      if (i_paddr == OSMC_ALLOC_OFS) begin
        o_alloc <= i_pwdata[3:0];
      end
    end
  end

  // Out-of-range torque writes saturate at the top of the range
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_torque <= OSMC_TORQUE_RST;
    end else if (wr_en && i_paddr == OSMC_TORQUE_OFS) begin
      if (i_pwdata[31:9] != 23'h000000 || i_pwdata[8:0] > OSMC_TORQUE_MAX) begin
        o_torque <= OSMC_TORQUE_MAX;
      end else begin
        o_torque <= i_pwdata[8:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_restart <= 1'b0;
      o_clear <= 1'b0;
    end else begin
      o_restart <= wr_en && i_paddr == OSMC_CTRL_OFS && i_pwdata[OSMC_CTRL_RESTART_BIT];
      o_clear <= wr_en && i_paddr == OSMC_CTRL_OFS && i_pwdata[OSMC_CTRL_CLEAR_BIT];
    end
  end

endmodule
`default_nettype wire

// File: hw/osmc_top.sv
// Functional notes
// - Forward limit active allows forward; inactive prohibits forward, flags forward overtravel.
// - Reverse limit active allows reverse; inactive prohibits reverse, flags reverse overtravel.
// - Forward disable field defaults 0; 1 ignores input; effective after restart.
// - Reverse disable field defaults 0; 1 ignores input; effective after restart.
// - Overtravel disabled unless input allocation setting is 1 or 2.
// - Stop on servo off, group-one, group-two alarm, safe state, overtravel.
// - Group-one selection: 0 brake/coast, 1 brake/brake hold, 2 coast/coast.
// - Overtravel selection: 0 brake/coast, 1 brake/hold, 2 reverse/clamp, 3 reverse/coast.
// - Reverse brake forces zero speed reference, bypasses soft start, limits torque.
// - Group-two selection codes 0 to 5 pick method and post state.
// - Group-two selection 5 treats group-two alarms as warnings, no stop.
// - With selection 5 the alarm stays latched until manual clear.
// - Group-two selection 3 or 4 decelerates under the reverse brake limit.
// - Torque limit 0 to 350 percent, default 300, effective immediately.
// - Limit is percent of rated torque, also clamped to motor maximum.
// - Zero clamp closes position loop at reference zero after stop.
// - Coasting releases control; brake hold keeps braking connection engaged.
`timescale 1ns/1ps
`default_nettype none
module osmc_top
  import osmc_pkg::*;
#(
  parameter int TORQUE_W = 9
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_forward_limit_input,
  input wire logic i_reverse_limit_input,
  input wire logic i_servo_on,
  input wire logic i_safe_state,
  input wire logic i_group_one_alarm,
  input wire logic i_group_two_alarm,
  input wire logic i_motor_standstill,
  input wire logic [TORQUE_W-1:0] i_motor_max_torque,
  output logic o_forward_prohibit,
  output logic o_reverse_prohibit,
  output logic o_forward_overtravel,
  output logic o_reverse_overtravel,
  output logic o_stop_active,
  output logic [1:0] o_stop_method,
  output logic [1:0] o_post_state,
  output logic o_power_enable,
  output logic o_dynamic_brake_hold,
  output logic o_speed_ref_zero,
  output logic o_softstart_bypass,
  output logic o_torque_limit_en,
  output logic [TORQUE_W-1:0] o_torque_limit,
  output logic o_zero_clamp_loop,
  output logic o_group_two_warning
);

  typedef enum logic [1:0] {
    OSMC_ST_RUN,
    OSMC_ST_STOPPING,
    OSMC_ST_STOPPED
  } osmc_state_type;

  logic [31:0] cfg_w;
  logic [3:0] alloc_w;
  logic [8:0] torque_w;
  logic restart_w;
  logic clear_w;
  logic [31:0] status_w;

  logic load_pending_r;
  logic fwd_dis_r;
  logic rev_dis_r;
  logic [1:0] g1_sel_r;
  logic [1:0] ot_sel_r;
  logic [2:0] g2_sel_r;
  logic [3:0] alloc_r;

  logic ot_enabled;
  logic fwd_ot_nxt;
  logic rev_ot_nxt;
  logic g2_latched_r;
  logic g2_stops;
  osmc_cause_type cause_nxt;
  osmc_cause_type cause_r;
  osmc_meth_type meth_w;
  osmc_post_type post_w;
  osmc_meth_type meth_r;
  osmc_post_type post_r;
  osmc_state_type state_r;
  osmc_state_type state_nxt;
  logic [TORQUE_W-1:0] torque_lim_nxt;

  // ==========================================================
  // Register slave
  // ==========================================================
  osmc_apb_regs u_regs (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_status(status_w),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_cfg(cfg_w),
    .o_alloc(alloc_w),
    .o_torque(torque_w),
    .o_restart(restart_w),
    .o_clear(clear_w)
  );

  assign status_w = {19'h00000, cause_r, state_r, post_r, meth_r,
                     g2_latched_r, o_stop_active, o_reverse_overtravel,
                     o_forward_overtravel};

  // ==========================================================
  // Restart-effective shadows
  // ==========================================================
  // Capture happens on the first edge after release, so a strap-like
  // setting never loads through the asynchronous reset path.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_pending_r <= 1'b1;
    end else begin
      load_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fwd_dis_r <= 1'b0;
      rev_dis_r <= 1'b0;
      g1_sel_r <= 2'h0;
      ot_sel_r <= 2'h0;
      g2_sel_r <= 3'h0;
      alloc_r <= OSMC_ALLOC_RST;
    end else if (load_pending_r || restart_w) begin
      fwd_dis_r <= cfg_w[OSMC_CFG_FWD_DIS_BIT];
      rev_dis_r <= cfg_w[OSMC_CFG_REV_DIS_BIT];
      g1_sel_r <= cfg_w[OSMC_CFG_G1_LSB +: 2];
      ot_sel_r <= cfg_w[OSMC_CFG_OT_LSB +: 2];
      g2_sel_r <= cfg_w[OSMC_CFG_G2_LSB +: 3];
      alloc_r <= alloc_w;
    end
  end

  // ==========================================================
  // Overtravel detection
  // ==========================================================
  assign ot_enabled = (alloc_r == OSMC_ALLOC_MAP_A) || (alloc_r == OSMC_ALLOC_MAP_B);
  assign fwd_ot_nxt = ot_enabled & ~fwd_dis_r & ~i_forward_limit_input;
  assign rev_ot_nxt = ot_enabled & ~rev_dis_r & ~i_reverse_limit_input;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_forward_overtravel <= 1'b0;
      o_reverse_overtravel <= 1'b0;
      o_forward_prohibit <= 1'b0;
      o_reverse_prohibit <= 1'b0;
    end else begin
      o_forward_overtravel <= fwd_ot_nxt;
      o_reverse_overtravel <= rev_ot_nxt;
      o_forward_prohibit <= fwd_ot_nxt;
      o_reverse_prohibit <= rev_ot_nxt;
    end
  end

  // ==========================================================
  // Group-two alarm latch
  // ==========================================================
  // A new alarm in the clearing cycle wins, so no event is dropped.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      g2_latched_r <= 1'b0;
    end else if (i_group_two_alarm) begin
      g2_latched_r <= 1'b1;
    end else if (clear_w) begin
      g2_latched_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_group_two_warning <= 1'b0;
    end else begin
      o_group_two_warning <= (g2_latched_r | i_group_two_alarm) &&
                             g2_sel_r == OSMC_G2_SEL_WARN;
    end
  end

  // ==========================================================
  // Stop cause with fixed priority
  // ==========================================================
  assign g2_stops = (g2_latched_r | i_group_two_alarm) && g2_sel_r != OSMC_G2_SEL_WARN;

  always_comb begin
    cause_nxt = OSMC_CAUSE_NONE;
    if (i_group_one_alarm || i_safe_state) begin
      cause_nxt = OSMC_CAUSE_G1;
    end else if (g2_stops) begin
      cause_nxt = OSMC_CAUSE_G2;
    end else if (fwd_ot_nxt || rev_ot_nxt) begin
      cause_nxt = OSMC_CAUSE_OT;
    end else if (!i_servo_on) begin
      cause_nxt = OSMC_CAUSE_SOFF;
    end
  end

  osmc_stop_select u_select (
    .i_cause(cause_nxt),
    .i_group_one_stop_sel(g1_sel_r),
    .i_overtravel_stop_sel(ot_sel_r),
    .i_group_two_stop_sel(g2_sel_r),
    .o_method(meth_w),
    .o_post(post_w)
  );

  // ==========================================================
  // Stop sequence
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OSMC_ST_RUN: begin
        if (cause_nxt != OSMC_CAUSE_NONE) begin
          state_nxt = OSMC_ST_STOPPING;
        end
      end
      OSMC_ST_STOPPING: begin
        if (cause_nxt == OSMC_CAUSE_NONE) begin
          state_nxt = OSMC_ST_RUN;
        end else if (i_motor_standstill) begin
          state_nxt = OSMC_ST_STOPPED;
        end
      end
      OSMC_ST_STOPPED: begin
        if (cause_nxt == OSMC_CAUSE_NONE) begin
          state_nxt = OSMC_ST_RUN;
        end
      end
      default: state_nxt = OSMC_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= OSMC_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // A higher cause arriving mid-stop re-selects method and post state.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cause_r <= OSMC_CAUSE_NONE;
      meth_r <= OSMC_METH_NONE;
      post_r <= OSMC_POST_OPER;
    end else begin
      cause_r <= cause_nxt;
      meth_r <= meth_w;
      post_r <= post_w;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_stop_active <= 1'b0;
      o_stop_method <= 2'h0;
      o_post_state <= 2'h0;
    end else begin
      o_stop_active <= state_nxt != OSMC_ST_RUN;
      o_stop_method <= (state_nxt == OSMC_ST_STOPPING) ? meth_w : OSMC_METH_NONE;
      o_post_state <= (state_nxt == OSMC_ST_STOPPED) ? post_w : OSMC_POST_OPER;
    end
  end

  // ==========================================================
  // Power stage commands
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_enable <= 1'b0;
      o_dynamic_brake_hold <= 1'b0;
      o_zero_clamp_loop <= 1'b0;
    end else begin
      case (state_nxt)
        OSMC_ST_STOPPING: begin
          o_power_enable <= meth_w == OSMC_METH_REVB;
          o_dynamic_brake_hold <= meth_w == OSMC_METH_DB;
          o_zero_clamp_loop <= 1'b0;
        end
        OSMC_ST_STOPPED: begin
          o_power_enable <= post_w == OSMC_POST_ZCLAMP;
          o_dynamic_brake_hold <= post_w == OSMC_POST_DB;
          o_zero_clamp_loop <= post_w == OSMC_POST_ZCLAMP;
        end
        default: begin
          o_power_enable <= 1'b1;
          o_dynamic_brake_hold <= 1'b0;
          o_zero_clamp_loop <= 1'b0;
        end
      endcase
    end
  end

  // Reverse brake: no ramp, hard zero speed, torque bounded by the limit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_speed_ref_zero <= 1'b0;
      o_softstart_bypass <= 1'b0;
      o_torque_limit_en <= 1'b0;
    end else begin
      o_speed_ref_zero <= state_nxt == OSMC_ST_STOPPING && meth_w == OSMC_METH_REVB;
      o_softstart_bypass <= state_nxt == OSMC_ST_STOPPING && meth_w == OSMC_METH_REVB;
      o_torque_limit_en <= state_nxt == OSMC_ST_STOPPING && meth_w == OSMC_METH_REVB;
    end
  end

  // Limit is in percent of rated torque; the motor ceiling wins when lower
  assign torque_lim_nxt = (TORQUE_W'(torque_w) > i_motor_max_torque) ?
                          i_motor_max_torque : TORQUE_W'(torque_w);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_torque_limit <= '0;
    end else begin
      o_torque_limit <= torque_lim_nxt;
    end
  end

endmodule
`default_nettype wire

// File: verification/osmc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module osmc_top_props
  import osmc_pkg::*;
#(
  parameter int TORQUE_W = 9
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_forward_limit_input,
  input wire logic i_reverse_limit_input,
  input wire logic i_servo_on,
  input wire logic i_safe_state,
  input wire logic i_group_one_alarm,
  input wire logic i_motor_standstill,
  input wire logic [TORQUE_W-1:0] i_motor_max_torque,
  input wire logic o_forward_prohibit,
  input wire logic o_reverse_prohibit,
  input wire logic o_forward_overtravel,
  input wire logic o_reverse_overtravel,
  input wire logic o_stop_active,
  input wire logic [1:0] o_stop_method,
  input wire logic [1:0] o_post_state,
  input wire logic o_power_enable,
  input wire logic o_dynamic_brake_hold,
  input wire logic o_speed_ref_zero,
  input wire logic o_softstart_bypass,
  input wire logic o_torque_limit_en,
  input wire logic [TORQUE_W-1:0] o_torque_limit,
  input wire logic o_zero_clamp_loop,
  input wire logic o_group_two_warning
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Stop sequence, overtravel flags and torque limit
  // ==========================================================
  sequence s_halting;
    (o_stop_method != 2'h0) && i_motor_standstill;
  endsequence
  sequence s_halted;
    s_halting ##1 o_stop_active;
  endsequence
  a_fwd_flag_pair: assert property (o_forward_prohibit == o_forward_overtravel)
    else $error("forward prohibit and overtravel differ");
  a_rev_flag_pair: assert property (o_reverse_prohibit == o_reverse_overtravel)
    else $error("reverse prohibit and overtravel differ");
  a_ot_needs_open: assert property (o_forward_overtravel |-> !$past(i_forward_limit_input))
    else $error("forward overtravel with limit closed");
  a_cause_stops: assert property ((!i_servo_on || i_safe_state || i_group_one_alarm) |=>
    o_stop_active) else $error("stop cause without stop");
  a_revb_outputs: assert property (o_stop_method == 2'h3 |->
    o_speed_ref_zero && o_softstart_bypass && o_torque_limit_en) else $error("reverse brake");
  a_torque_clamp: assert property (o_torque_limit <= $past(i_motor_max_torque))
    else $error("torque limit above motor maximum");
  a_torque_range: assert property (o_torque_limit <= OSMC_TORQUE_MAX)
    else $error("torque limit above range");
  a_clamp_post: assert property (o_zero_clamp_loop |-> o_post_state == 2'h3)
    else $error("zero clamp outside clamp state");
  a_hold_no_power: assert property (o_dynamic_brake_hold |-> !o_power_enable)
    else $error("brake hold while powered");
  a_halt_post: assert property (s_halted |-> o_stop_method == 2'h0 && o_post_state != 2'h0)
    else $error("no post state after standstill");
  a_warn_no_stop: assert property (o_group_two_warning && i_servo_on && !i_safe_state &&
    !i_group_one_alarm && i_forward_limit_input && i_reverse_limit_input |=> !o_stop_active)
    else $error("warning stop");
endmodule
bind osmc_top osmc_top_props #(.TORQUE_W(TORQUE_W)) u_props (.*);
`default_nettype wire

// File: verification/osmc_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module osmc_motor_model (
  input wire logic i_clk,
  input wire logic i_fwd_open,
  input wire logic i_rev_open,
  input wire logic i_stop_active,
  input wire logic [3:0] i_decel,
  output logic o_forward_limit_input,
  output logic o_reverse_limit_input,
  output logic o_motor_standstill
);
  logic [3:0] cnt_r = 4'h0;
  // Normally closed switches: an open contact reads low
  assign o_forward_limit_input = !i_fwd_open;
  assign o_reverse_limit_input = !i_rev_open;
  // Speed decays over a set number of cycles once stopping begins
  assign o_motor_standstill = i_stop_active && (cnt_r >= i_decel);
  always_ff @(posedge i_clk) begin
    if (!i_stop_active) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hF) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: verification/osmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module osmc_top_tb
  import osmc_pkg::*;
;
  logic i_clk = 1'h0, i_arst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic i_servo_on = 1'h1, i_safe_state = 1'h0, i_group_one_alarm = 1'h0;
  logic i_group_two_alarm = 1'h0, fwd_open = 1'h0, rev_open = 1'h0, err;
  logic [8:0] i_motor_max_torque = 9'h0C8, o_torque_limit;
  logic [3:0] decel = 4'h6;
  logic i_forward_limit_input, i_reverse_limit_input, i_motor_standstill, o_pready, o_pslverr;
  logic o_forward_prohibit, o_reverse_prohibit, o_forward_overtravel, o_reverse_overtravel;
  logic o_stop_active, o_power_enable, o_dynamic_brake_hold, o_speed_ref_zero;
  logic o_softstart_bypass, o_torque_limit_en, o_zero_clamp_loop, o_group_two_warning;
  logic [1:0] o_stop_method, o_post_state;
  int num_errors = 0, compares = 0;
  // Each entry: cause(2) selection(3) method(2) post state(2)
  logic [8:0] tbl [13] = '{9'h005, 9'h016, 9'h029, 9'h085, 9'h096, 9'h0AF, 9'h0BD,
    9'h105, 9'h116, 9'h129, 9'h13E, 9'h14D, 9'h150};
  osmc_top dut (.*);
  osmc_motor_model u_motor (.i_clk(i_clk), .i_fwd_open(fwd_open), .i_rev_open(rev_open),
    .i_stop_active(o_stop_active), .i_decel(decel), .o_forward_limit_input(i_forward_limit_input),
    .o_reverse_limit_input(i_reverse_limit_input), .o_motor_standstill(i_motor_standstill));
  always #12.5 i_clk = ~i_clk;
  // ==========================================================
  // Bench tasks
  // ==========================================================
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    do @(posedge i_clk); while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic restart(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    apb(1'h1, OSMC_CTRL_OFS, 32'h1);
    tick(3);
  endtask
  task automatic run_stop(input logic [8:0] e);
    restart(OSMC_CFG_OFS, 32'(e[6:4]) << (4 + 4 * e[8:7]));
    i_safe_state <= (e[8:7] == 2'h0);
    fwd_open <= (e[8:7] == 2'h1);
    i_group_two_alarm <= (e[8:7] == 2'h2);
    tick(2);
    check({o_forward_prohibit, o_forward_overtravel}, {2{e[8:7] == 2'h1}}, "fwd ot");
    check(o_stop_method, e[3:2], "method");
    check(o_stop_active, e[3:2] != 2'h0, "stop");
    check({o_speed_ref_zero, o_softstart_bypass, o_torque_limit_en},
      {3{e[3:2] == 2'h3}}, "revb");
    while (o_stop_method != 2'h0) tick(1);
    tick(1);
    check(o_post_state, e[1:0], "post");
    check(o_zero_clamp_loop, e[1:0] == 2'h3, "clamp");
    check({o_dynamic_brake_hold, o_power_enable}, {e[1:0] == 2'h2,
      e[1:0] == 2'h0 || e[1:0] == 2'h3}, "hold");
    i_safe_state <= 1'h0;
    fwd_open <= 1'h0;
    i_group_two_alarm <= 1'h0;
    tick(3);
    check({o_stop_active, o_group_two_warning}, {e[8:7] == 2'h2 && e[3:2] != 2'h0,
      e[8:7] == 2'h2 && e[3:2] == 2'h0}, "latched");
    apb(1'h1, OSMC_CTRL_OFS, 32'h2);
    tick(3);
    check({o_stop_active, o_group_two_warning}, 2'h0, "cleared");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    tick(4);
    i_arst_n <= 1'h1;
    tick(1);
    apb(1'h0, OSMC_CFG_OFS, 32'h0);
    check(rd, 32'h0, "cfg");
    apb(1'h0, OSMC_ALLOC_OFS, 32'h0);
    check(rd, 32'h1, "alloc");
    apb(1'h0, OSMC_TORQUE_OFS, 32'h0);
    check(rd, 32'h12C, "torque");
    check(o_torque_limit, 9'h0C8, "motor clamp");
    i_motor_max_torque <= 9'h1FF;
    apb(1'h1, OSMC_TORQUE_OFS, 32'h190);
    tick(2);
    check(o_torque_limit, 9'h15E, "torque sat");
    apb(1'h0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1, "slverr");
    check(rd, 32'h0, "unmapped");
    $display("register test done");
    foreach (tbl[i]) begin
      decel <= i[0] ? 4'h4 : 4'hC;
      run_stop(tbl[i]);
    end
    $display("stop method test done");
    restart(OSMC_CFG_OFS, 32'h200);
    fwd_open <= 1'h1;
    i_group_one_alarm <= 1'h1;
    tick(2);
    check(o_stop_method, 2'h1, "priority");
    apb(1'h0, OSMC_STATUS_OFS, 32'h0);
    check(rd[12:10], 3'h1, "cause g1");
    fwd_open <= 1'h0;
    i_group_one_alarm <= 1'h0;
    i_servo_on <= 1'h0;
    tick(3);
    apb(1'h0, OSMC_STATUS_OFS, 32'h0);
    check(rd[12:10], 3'h4, "cause servo");
    i_servo_on <= 1'h1;
    $display("priority test done");
    restart(OSMC_CFG_OFS, 32'h3);
    fwd_open <= 1'h1;
    rev_open <= 1'h1;
    apb(1'h1, OSMC_CFG_OFS, 32'h0);
    tick(3);
    check({o_forward_overtravel, o_reverse_overtravel}, 2'h0, "disabled");
    apb(1'h1, OSMC_ALLOC_OFS, 32'h0);
    restart(OSMC_CFG_OFS, 32'h0);
    check({o_forward_overtravel, o_stop_active}, 2'h0, "unallocated");
    restart(OSMC_ALLOC_OFS, 32'h2);
    check({o_reverse_prohibit, o_reverse_overtravel}, 2'h3, "rev ot");
    $display("limit enable test done");
    give_verdict();
  end
  initial begin
    tick(20000);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
